// ### shared/lio_map.svh
// Offsets, fields, reset values and timing of the logical I/O bank
`ifndef LIO_MAP_SVH
`define LIO_MAP_SVH

// Register byte offsets (one aligned 32-bit word each)
`define LIO_ADDR_SET_CMD    8'h00
`define LIO_ADDR_CLR_CMD    8'h04
`define LIO_ADDR_MODE       8'h08
`define LIO_ADDR_IN_STATUS  8'h0c
`define LIO_ADDR_OUT_STATUS 8'h10
`define LIO_ADDR_EVT_EN     8'h14
`define LIO_ADDR_IRQ_STAT   8'h18
`define LIO_ADDR_IRQ_MASK   8'h1c
`define LIO_ADDR_IN_ON      8'h20
`define LIO_ADDR_IN_OFF     8'h24
`define LIO_ADDR_OUT_ON     8'h28
`define LIO_ADDR_OUT_OFF    8'h2c
`define LIO_ADDR_STAMP_SEL  8'h30
`define LIO_ADDR_STAMP_DATA 8'h34
`define LIO_ADDR_TIME       8'h38
`define LIO_ADDR_RT_BLOCK   8'h40
`define LIO_ADDR_RT_GROUP   8'h44
`define LIO_ADDR_RT_RELAY   8'h48
`define LIO_ADDR_RT_LED     8'h4c

// Field positions
`define LIO_EVT_EN_ON_BIT   0
`define LIO_EVT_EN_OFF_BIT  1
`define LIO_IRQ_IN_BIT      0
`define LIO_IRQ_OUT_BIT     1

// Reset values
`define LIO_EVT_EN_RST      32'h0000_0003
`define LIO_MODE_RST        32'h0000_0000
`define LIO_MASK_RST        32'h0000_0000
`define LIO_ROUTE_RST       32'h0000_0000

// Bus answers
`define LIO_RESP_OKAY       2'h0
`define LIO_RESP_SLVERR     2'h2

// Timing: pulse length and system clock
`define LIO_PULSE_TIME_US   64'd5000
`define LIO_CLK_HZ          64'd200000000
`define LIO_PULSE_CYCLES    ((`LIO_PULSE_TIME_US * `LIO_CLK_HZ) / 64'd1000000)

`endif

// ### shared/lio_pkg.sv
// Types shared by the logical I/O bank
package lio_pkg;
    typedef logic [31:0] lio_word_type;
    typedef logic [5:0]  lio_stamp_idx_type;
    typedef enum logic {
        LIO_WR_COLLECT,
        LIO_WR_RESPOND
    } lio_wr_state_type;
endpackage

// ### hw/lio_pulse_timer.sv
// One self-clearing pulse timer for a logical input in pulse mode
`timescale 1ns/1ps
`default_nettype none

module lio_pulse_timer #(
    parameter int unsigned PULSE_CYCLES = 1000000
) (
    // Clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // Control
    input  wire logic start,
    input  wire logic cancel,
    // Status
    output logic      active
);
    logic [31:0] count_ff;
    logic        active_ff;

    // A new start reloads the count even mid-pulse, so the pulse restarts
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_ff  <= 32'h0;
            active_ff <= 1'b0;
        end else if (start) begin
            count_ff  <= 32'(PULSE_CYCLES - 1);
            active_ff <= 1'b1;
        end else if (cancel) begin
            count_ff  <= 32'h0;
            active_ff <= 1'b0;
        end else if (active_ff) begin
            if (count_ff == 32'h0) begin
                active_ff <= 1'b0;
            end else begin
                count_ff <= count_ff - 32'h1;
            end
        end
    end

    assign active = active_ff;
endmodule
`default_nettype wire

// ### hw/lio_bank.sv
// Logical input/output signal bank with AXI4-Lite registers and events
//
// Chosen here: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "lio_map.svh"

// Contract
// - Thirty-two independent logical inputs, each commanded and observed separately.
// - All logical input states are cleared to zero on every restart.
// - Each input has its own mode bit: hold or self-clearing pulse.
// - Hold mode: set makes status one until a clear or restart.
// - Pulse mode: set makes status one, then it returns to zero after 5 ms.
// - Both local switch and remote supervisory link may set or clear inputs.
// - Thirty-two logical outputs, each taken from a user logic result.
// - Each output can be routed to blocking, group change, relays and LEDs.
// - Present state of every logical output is readable for reporting.
// - Rising change gives ON event, falling gives OFF; separate enables store each.
// - Each stored event keeps a time stamp taken at the change; the code keeps one stamp per signal, that of its last stored change.
module lio_bank #(
    parameter int unsigned PULSE_CYCLES = int'(`LIO_PULSE_CYCLES)
) (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write address
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    // AXI4-Lite write data
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    // AXI4-Lite write response
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    // AXI4-Lite read address
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    // AXI4-Lite read data
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    // Local mimic virtual switch commands, one-cycle pulses
    input  wire logic [31:0] mimic_set_cmd,
    input  wire logic [31:0] mimic_clr_cmd,
    // User logic results and logical input status
    input  wire logic [31:0] user_logic_output_n,
    output logic [31:0]      commanded_input_n,
    // Routed logical outputs
    output logic [31:0]      block_ctrl,
    output logic [31:0]      group_ctrl,
    output logic [31:0]      relay_ctrl,
    output logic [31:0]      led_ctrl,
    // Interrupt
    output logic             irq
);
    // Decode helpers
    function automatic logic is_mapped(input logic [7:0] addr);
        unique case (addr)
            `LIO_ADDR_SET_CMD, `LIO_ADDR_CLR_CMD, `LIO_ADDR_MODE,
            `LIO_ADDR_IN_STATUS, `LIO_ADDR_OUT_STATUS, `LIO_ADDR_EVT_EN,
            `LIO_ADDR_IRQ_STAT, `LIO_ADDR_IRQ_MASK, `LIO_ADDR_IN_ON,
            `LIO_ADDR_IN_OFF, `LIO_ADDR_OUT_ON, `LIO_ADDR_OUT_OFF,
            `LIO_ADDR_STAMP_SEL, `LIO_ADDR_STAMP_DATA, `LIO_ADDR_TIME,
            `LIO_ADDR_RT_BLOCK, `LIO_ADDR_RT_GROUP, `LIO_ADDR_RT_RELAY,
            `LIO_ADDR_RT_LED: is_mapped = 1'b1;
            default:          is_mapped = 1'b0;
        endcase
    endfunction
    function automatic lio_pkg::lio_word_type strb_mask(input logic [3:0] strb);
        strb_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    endfunction
    function automatic lio_pkg::lio_word_type apply_strb(
        input lio_pkg::lio_word_type old_val,
        input lio_pkg::lio_word_type new_val,
        input logic [3:0]            strb
    );
        lio_pkg::lio_word_type m;
        m = strb_mask(strb);
        apply_strb = (old_val & ~m) | (new_val & m);
    endfunction
    // Write channel state
    lio_pkg::lio_wr_state_type  wr_state_ff;
    logic                       aw_held_ff, w_held_ff, wr_do;
    logic [7:0]                 wr_addr_ff;
    lio_pkg::lio_word_type      wr_data_ff;
    logic [3:0]                 wr_strb_ff;
    logic [1:0]                 bresp_ff;
    // Read channel state
    logic                       rvalid_ff, rd_do;
    lio_pkg::lio_word_type      rdata_ff;
    logic [1:0]                 rresp_ff;
    logic [7:0]                 rd_addr;
    // Software visible registers
    lio_pkg::lio_word_type      mode_ff, evt_en_ff, irq_mask_ff, time_ff;
    logic [1:0]                 irq_stat_ff;
    lio_pkg::lio_word_type      in_on_ff, in_off_ff, out_on_ff, out_off_ff;
    lio_pkg::lio_stamp_idx_type stamp_sel_ff;
    lio_pkg::lio_word_type      rt_block_ff, rt_group_ff, rt_relay_ff, rt_led_ff;
    lio_pkg::lio_word_type      stamp_mem [0:63];
    // Signal state
    lio_pkg::lio_word_type      hold_ff, in_status_ff, in_prev_ff, out_status_ff, out_prev_ff;
    lio_pkg::lio_word_type      pulse_act, set_cmd, clr_cmd, bus_set, bus_clr, nxt_in_status;
    lio_pkg::lio_word_type      in_rise, in_fall, out_rise, out_fall;
    lio_pkg::lio_word_type      in_on_set, in_off_set, out_on_set, out_off_set;
    logic                       en_on, en_off;
    // Handshake outputs follow the holding flags
    assign s_axi_awready = ~aw_held_ff & (wr_state_ff == lio_pkg::LIO_WR_COLLECT);
    assign s_axi_wready  = ~w_held_ff & (wr_state_ff == lio_pkg::LIO_WR_COLLECT);
    assign s_axi_bvalid  = (wr_state_ff == lio_pkg::LIO_WR_RESPOND);
    assign s_axi_bresp   = bresp_ff;
    assign wr_do         = aw_held_ff & w_held_ff & (wr_state_ff == lio_pkg::LIO_WR_COLLECT);
    // Write channel: address and data are taken in either order, then answered
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_state_ff <= lio_pkg::LIO_WR_COLLECT;
            aw_held_ff  <= 1'b0;
            w_held_ff   <= 1'b0;
            wr_addr_ff  <= 8'h00;
            wr_data_ff  <= 32'h0;
            wr_strb_ff  <= 4'h0;
            bresp_ff    <= `LIO_RESP_OKAY;
        end else begin
            unique case (wr_state_ff)
                lio_pkg::LIO_WR_COLLECT: begin
                    if (s_axi_awvalid && s_axi_awready) begin
                        aw_held_ff <= 1'b1;
                        wr_addr_ff <= {s_axi_awaddr[7:2], 2'b00};
                    end
                    if (s_axi_wvalid && s_axi_wready) begin
                        w_held_ff  <= 1'b1;
                        wr_data_ff <= s_axi_wdata;
                        wr_strb_ff <= s_axi_wstrb;
                    end
                    if (wr_do) begin
                        aw_held_ff  <= 1'b0;
                        w_held_ff   <= 1'b0;
                        bresp_ff    <= is_mapped(wr_addr_ff) ? `LIO_RESP_OKAY
                                                             : `LIO_RESP_SLVERR;
                        wr_state_ff <= lio_pkg::LIO_WR_RESPOND;
                    end
                end
                lio_pkg::LIO_WR_RESPOND: begin
                    if (s_axi_bready) begin
                        wr_state_ff <= lio_pkg::LIO_WR_COLLECT;
                    end
                end
            endcase
        end
    end
    // Read channel: one read in flight, answered the cycle after the address
    assign s_axi_arready = ~rvalid_ff;
    assign s_axi_rvalid  = rvalid_ff;
    assign s_axi_rdata   = rdata_ff;
    assign s_axi_rresp   = rresp_ff;
    assign rd_do         = s_axi_arvalid & ~rvalid_ff;
    assign rd_addr       = {s_axi_araddr[7:2], 2'b00};
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= 32'h0;
            rresp_ff  <= `LIO_RESP_OKAY;
        end else if (rd_do) begin
            rvalid_ff <= 1'b1;
            rresp_ff  <= is_mapped(rd_addr) ? `LIO_RESP_OKAY : `LIO_RESP_SLVERR;
            unique case (rd_addr)
                `LIO_ADDR_MODE:       rdata_ff <= mode_ff;
                `LIO_ADDR_IN_STATUS:  rdata_ff <= in_status_ff;
                `LIO_ADDR_OUT_STATUS: rdata_ff <= out_status_ff;
                `LIO_ADDR_EVT_EN:     rdata_ff <= evt_en_ff;
                `LIO_ADDR_IRQ_STAT:   rdata_ff <= {30'h0, irq_stat_ff};
                `LIO_ADDR_IRQ_MASK:   rdata_ff <= irq_mask_ff;
                `LIO_ADDR_IN_ON:      rdata_ff <= in_on_ff;
                `LIO_ADDR_IN_OFF:     rdata_ff <= in_off_ff;
                `LIO_ADDR_OUT_ON:     rdata_ff <= out_on_ff;
                `LIO_ADDR_OUT_OFF:    rdata_ff <= out_off_ff;
                `LIO_ADDR_STAMP_SEL:  rdata_ff <= {26'h0, stamp_sel_ff};
                `LIO_ADDR_STAMP_DATA: rdata_ff <= stamp_mem[stamp_sel_ff];
                `LIO_ADDR_TIME:       rdata_ff <= time_ff;
                `LIO_ADDR_RT_BLOCK:   rdata_ff <= rt_block_ff;
                `LIO_ADDR_RT_GROUP:   rdata_ff <= rt_group_ff;
                `LIO_ADDR_RT_RELAY:   rdata_ff <= rt_relay_ff;
                `LIO_ADDR_RT_LED:     rdata_ff <= rt_led_ff;
                default:              rdata_ff <= 32'h0;
            endcase
        end else if (s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end
    // Configuration registers written over the bus
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_ff      <= `LIO_MODE_RST;
            evt_en_ff    <= `LIO_EVT_EN_RST;
            irq_mask_ff  <= `LIO_MASK_RST;
            stamp_sel_ff <= 6'h00;
            rt_block_ff  <= `LIO_ROUTE_RST;
            rt_group_ff  <= `LIO_ROUTE_RST;
            rt_relay_ff  <= `LIO_ROUTE_RST;
            rt_led_ff    <= `LIO_ROUTE_RST;
        end else if (wr_do) begin
            unique case (wr_addr_ff)
                `LIO_ADDR_MODE:      mode_ff <= apply_strb(mode_ff, wr_data_ff, wr_strb_ff);
                `LIO_ADDR_EVT_EN:    evt_en_ff <= apply_strb(evt_en_ff, wr_data_ff, wr_strb_ff);
                `LIO_ADDR_IRQ_MASK:  irq_mask_ff <= apply_strb(irq_mask_ff, wr_data_ff, wr_strb_ff);
                `LIO_ADDR_STAMP_SEL: begin
                    if (wr_strb_ff[0]) begin
                        stamp_sel_ff <= wr_data_ff[5:0];
                    end
                end
                `LIO_ADDR_RT_BLOCK:  rt_block_ff <= apply_strb(rt_block_ff, wr_data_ff, wr_strb_ff);
                `LIO_ADDR_RT_GROUP:  rt_group_ff <= apply_strb(rt_group_ff, wr_data_ff, wr_strb_ff);
                `LIO_ADDR_RT_RELAY:  rt_relay_ff <= apply_strb(rt_relay_ff, wr_data_ff, wr_strb_ff);
                `LIO_ADDR_RT_LED:    rt_led_ff <= apply_strb(rt_led_ff, wr_data_ff, wr_strb_ff);
                default: ;
            endcase
        end
    end
    // Commands from the link and the local switch merge; clear beats set on the same bit
    assign bus_set = (wr_do && wr_addr_ff == `LIO_ADDR_SET_CMD)
                   ? (wr_data_ff & strb_mask(wr_strb_ff)) : 32'h0;
    assign bus_clr = (wr_do && wr_addr_ff == `LIO_ADDR_CLR_CMD)
                   ? (wr_data_ff & strb_mask(wr_strb_ff)) : 32'h0;
    assign clr_cmd = bus_clr | mimic_clr_cmd;
    assign set_cmd = (bus_set | mimic_set_cmd) & ~clr_cmd;
    // One timer per input; holding mode or a clear cancels a running pulse
    for (genvar i = 0; i < 32; i++) begin : g_pulse
        lio_pulse_timer #(
            .PULSE_CYCLES (PULSE_CYCLES)
        ) u_timer (
            .aclk    (aclk),
            .aresetn (aresetn),
            .start   (set_cmd[i] & mode_ff[i]),
            .cancel  (clr_cmd[i] | ~mode_ff[i]),
            .active  (pulse_act[i])
        );
    end
    // Hold latch only tracks inputs in hold mode, so a mode change never leaves a stale one
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hold_ff <= 32'h0;
        end else begin
            hold_ff <= ~mode_ff & ((hold_ff | set_cmd) & ~clr_cmd);
        end
    end
    // Status is the hold latch or the pulse timer, per input
    assign nxt_in_status = (hold_ff & ~mode_ff) | (pulse_act & mode_ff);

    // Registered statuses; the user logic results share this clock, so no synchroniser
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            in_status_ff  <= 32'h0;
            in_prev_ff    <= 32'h0;
            out_status_ff <= 32'h0;
            out_prev_ff   <= 32'h0;
        end else begin
            in_status_ff  <= nxt_in_status;
            in_prev_ff    <= in_status_ff;
            out_status_ff <= user_logic_output_n;
            out_prev_ff   <= out_status_ff;
        end
    end

    assign commanded_input_n = in_status_ff;

    // Routing masks pick the destinations of each logical output
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            block_ctrl <= 32'h0;
            group_ctrl <= 32'h0;
            relay_ctrl <= 32'h0;
            led_ctrl   <= 32'h0;
        end else begin
            block_ctrl <= user_logic_output_n & rt_block_ff;
            group_ctrl <= user_logic_output_n & rt_group_ff;
            relay_ctrl <= user_logic_output_n & rt_relay_ff;
            led_ctrl   <= user_logic_output_n & rt_led_ff;
        end
    end

    // Edge detection and event enables
    assign en_on       = evt_en_ff[`LIO_EVT_EN_ON_BIT];
    assign en_off      = evt_en_ff[`LIO_EVT_EN_OFF_BIT];
    assign in_rise     = in_status_ff & ~in_prev_ff;
    assign in_fall     = ~in_status_ff & in_prev_ff;
    assign out_rise    = out_status_ff & ~out_prev_ff;
    assign out_fall    = ~out_status_ff & out_prev_ff;
    assign in_on_set   = en_on ? in_rise : 32'h0;
    assign in_off_set  = en_off ? in_fall : 32'h0;
    assign out_on_set  = en_on ? out_rise : 32'h0;
    assign out_off_set = en_off ? out_fall : 32'h0;

    // Sticky event bits clear on read; a new event in the read cycle survives
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            in_on_ff   <= 32'h0;
            in_off_ff  <= 32'h0;
            out_on_ff  <= 32'h0;
            out_off_ff <= 32'h0;
        end else begin
            in_on_ff   <= (rd_do && rd_addr == `LIO_ADDR_IN_ON ? 32'h0 : in_on_ff)
                          | in_on_set;
            in_off_ff  <= (rd_do && rd_addr == `LIO_ADDR_IN_OFF ? 32'h0 : in_off_ff)
                          | in_off_set;
            out_on_ff  <= (rd_do && rd_addr == `LIO_ADDR_OUT_ON ? 32'h0 : out_on_ff)
                          | out_on_set;
            out_off_ff <= (rd_do && rd_addr == `LIO_ADDR_OUT_OFF ? 32'h0 : out_off_ff)
                          | out_off_set;
        end
    end

    // Free-running time base for stamps; wraps after 2^32 cycles
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            time_ff <= 32'h0;
        end else begin
            time_ff <= time_ff + 32'h1;
        end
    end

    // Stamp of the last stored change; entries 0-31 inputs, 32-63 outputs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int k = 0; k < 64; k++) begin
                stamp_mem[k] <= 32'h0;
            end
        end else begin
            for (int k = 0; k < 32; k++) begin
                if (in_on_set[k] || in_off_set[k]) begin
                    stamp_mem[k] <= time_ff;
                end
                if (out_on_set[k] || out_off_set[k]) begin
                    stamp_mem[k + 32] <= time_ff;
                end
            end
        end
    end

    // Interrupt status: one bit per group, read clears, set wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat_ff <= 2'h0;
        end else begin
            irq_stat_ff[`LIO_IRQ_IN_BIT] <=
                ((rd_do && rd_addr == `LIO_ADDR_IRQ_STAT) ? 1'b0 : irq_stat_ff[`LIO_IRQ_IN_BIT])
                | (|(in_on_set | in_off_set));
            irq_stat_ff[`LIO_IRQ_OUT_BIT] <=
                ((rd_do && rd_addr == `LIO_ADDR_IRQ_STAT) ? 1'b0 : irq_stat_ff[`LIO_IRQ_OUT_BIT])
                | (|(out_on_set | out_off_set));
        end
    end

    // Level interrupt while any unmasked status bit is set
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat_ff & irq_mask_ff[1:0]);
        end
    end
endmodule
`default_nettype wire

// ### verification/lio_bank_chk.sv
// Port checker of the logical I/O bank
`timescale 1ns/1ps
`default_nettype none
module lio_bank_chk #(parameter int unsigned PULSE_CYCLES = 20) (
    // Clock, reset and bus handshakes
    input wire logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid,
    input wire logic s_axi_wready, s_axi_bvalid, s_axi_arvalid, s_axi_arready,
    input wire logic s_axi_rvalid,
    // Signal bank
    input wire logic [31:0] mimic_set_cmd, mimic_clr_cmd, user_logic_output_n,
    input wire logic [31:0] commanded_input_n, block_ctrl, led_ctrl
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Restart wipes every input, so this one must run through reset
    rst_clear_a: assert property (disable iff (1'h0)
        !aresetn |=> commanded_input_n == 32'h0) else $error("inputs kept over reset");
    // Block and LED copies never show a bit the user logic did not drive
    route_mask_a: assert property (
        ((block_ctrl | led_ctrl) & ~$past(user_logic_output_n)) == 32'h0)
        else $error("routed bit without source");
    // Depth three covers sample, hold flop and output flop
    mimic_set_a: assert property (
        ($past(mimic_set_cmd, 3) & ~$past(mimic_clr_cmd, 3) & ~commanded_input_n) == 32'h0)
        else $error("switch set lost");
    clear_wins_a: assert property (
        ($past(mimic_clr_cmd, 3) & commanded_input_n) == 32'h0) else $error("clear ignored");
    wr_busy_a: assert property (
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken early");
    wr_answer_a: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[2:3] s_axi_bvalid)
        else $error("no write answer");
    rd_answer_a: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no read answer");
    rd_block_a: assert property (
        s_axi_rvalid |-> !s_axi_arready) else $error("read taken early");
endmodule
bind lio_bank lio_bank_chk #(.PULSE_CYCLES(PULSE_CYCLES)) u_chk (.aclk, .aresetn,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .mimic_set_cmd, .mimic_clr_cmd,
    .user_logic_output_n, .commanded_input_n, .block_ctrl, .led_ctrl);
`default_nettype wire

// ### verification/lio_partner.sv
// Far-side model: mimic switch presses and user logic results
`timescale 1ns/1ps
`default_nettype none
module lio_partner (
    // Clock, reset and bench requests
    input  wire logic        aclk, aresetn, fire,
    input  wire logic [31:0] set_bits, clr_bits, ulo_req,
    // Towards the bank
    output logic      [31:0] mimic_set_cmd, mimic_clr_cmd, user_logic_output_n
);
    // A press lasts one cycle, since a held level would re-trigger each cycle
    always_ff @(posedge aclk) begin
        mimic_set_cmd <= (aresetn && fire) ? set_bits : 32'h0;
        mimic_clr_cmd <= (aresetn && fire) ? clr_bits : 32'h0;
    end
    // User logic results move on the system clock, quiet through reset
    always_ff @(posedge aclk) begin
        user_logic_output_n <= aresetn ? ulo_req : 32'h0;
    end
endmodule
`default_nettype wire

// ### verification/tb_lio_bank.sv
// Self-checking bench of the logical I/O bank
`timescale 1ns/1ps
`default_nettype none
module tb_lio_bank;
    localparam int P = 20;
    typedef struct {logic [7:0] a; logic [31:0] d, e; logic [1:0] r;} lio_row_type;
    logic aclk = 1'h0, aresetn = 1'h0, awv = 1'h0, wv = 1'h0, bre = 1'h0, arv = 1'h0;
    logic rre = 1'h0, fire = 1'h0, awr, wrr, bv, arr, rv, irq;
    logic [31:0] awa = 32'h0, wd = 32'h0, ara = 32'h0, sb = 32'h0, cb = 32'h0, ulo = 32'h0;
    logic [31:0] rdat, ms, mc, uo, ci, bk, gp, ry, ld, got, t0, t1;
    logic [1:0] br, rr, rsp;
    int n_mismatch = 0, compares = 0, i, w;
    // Write, read back, expected data and answer
    lio_row_type rows [8] = '{'{8'h08, 32'h00f0_0002, 32'h00f0_0002, 2'h0},
        '{8'h14, 32'h1, 32'h1, 2'h0}, '{8'h1c, 32'h1, 32'h1, 2'h0},
        '{8'h30, 32'hffff_ff02, 32'h2, 2'h0}, '{8'h40, 32'hffff_ffff, 32'hffff_ffff, 2'h0},
        '{8'h4c, 32'hffff, 32'hffff, 2'h0}, '{8'h0c, 32'hffff_ffff, 32'h0, 2'h0},
        '{8'h3c, 32'hffff_ffff, 32'h0, 2'h2}};
    initial forever #2.5 aclk = ~aclk;
    lio_bank #(.PULSE_CYCLES(P)) i_dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_awprot(3'h0),
        .s_axi_wvalid(wv), .s_axi_wready(wrr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
        .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_bresp(br), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_arprot(3'h0), .s_axi_rvalid(rv),
        .s_axi_rready(rre), .s_axi_rdata(rdat), .s_axi_rresp(rr), .mimic_set_cmd(ms),
        .mimic_clr_cmd(mc), .user_logic_output_n(uo), .commanded_input_n(ci),
        .block_ctrl(bk), .group_ctrl(gp), .relay_ctrl(ry), .led_ctrl(ld), .irq(irq));
    lio_partner i_far (.aclk(aclk), .aresetn(aresetn), .fire(fire), .set_bits(sb),
        .clr_bits(cb), .ulo_req(ulo), .mimic_set_cmd(ms), .mimic_clr_cmd(mc),
        .user_logic_output_n(uo));
    task automatic summarize();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    // A wait that runs out ends the run as a failure
    task automatic tmo(input int n);
        if (n >= 99) begin
            n_mismatch++;
            summarize();
        end
    endtask
    // Address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge aclk);
        awa <= {24'h0, a};
        wd <= d;
        awv <= 1'h1;
        wv <= 1'h1;
        bre <= 1'h1;
        for (n = 0; n < 99; n++) begin
            @(posedge aclk);
            if (awr) awv <= 1'h0;
            if (wrr) wv <= 1'h0;
            if (bv) break;
        end
        rsp = br;
        bre <= 1'h0;
        tmo(n);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        int n;
        @(posedge aclk);
        ara <= {24'h0, a};
        arv <= 1'h1;
        rre <= 1'h1;
        for (n = 0; n < 99; n++) begin
            @(posedge aclk);
            if (arr) arv <= 1'h0;
            if (rv) break;
        end
        d = rdat;
        rsp = rr;
        rre <= 1'h0;
        tmo(n);
    endtask
    task automatic mim(input logic [31:0] s, input logic [31:0] c);
        @(posedge aclk);
        sb <= s;
        cb <= c;
        fire <= 1'h1;
        @(posedge aclk);
        fire <= 1'h0;
    endtask
    // Counts the cycles input 1 stays high
    task automatic pw(output int wd_n);
        int n;
        wd_n = 0;
        for (n = 0; n < 99 && ci[1] !== 1'h1; n++) @(posedge aclk);
        for (n = 0; n < 999 && ci[1] === 1'h1; n++) begin
            @(posedge aclk);
            wd_n++;
        end
    endtask
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'h1;
        rd(8'h14, got);
        chk("evt_en reset", 32'h3, got);
        chk("inputs reset", 32'h0, ci);
        for (i = 0; i < 8; i++) begin
            wr(rows[i].a, rows[i].d);
            chk("bresp", 32'(rows[i].r), 32'(rsp));
            rd(rows[i].a, got);
            chk("rdata", rows[i].e, got);
            chk("rresp", 32'(rows[i].r), 32'(rsp));
        end
        wr(8'h00, 32'h8000_0001);
        repeat (4) @(posedge aclk);
        rd(8'h0c, got);
        chk("hold set", 32'h8000_0001, got);
        wr(8'h04, 32'h1);
        mim(32'h0, 32'h8000_0000);
        repeat (4) @(posedge aclk);
        chk("hold clear", 32'h0, ci);
        fork pw(w); mim(32'h2, 32'h0); join
        chk("pulse width", P, w);
        // Second press twelve cycles after the first
        fork pw(w); begin mim(32'h2, 32'h0); repeat (10) @(posedge aclk); mim(32'h2, 32'h0); end join
        chk("restart width", P + 12, w);
        $display("input modes done");
        rd(8'h20, got);
        rd(8'h24, got);
        rd(8'h18, got);
        rd(8'h38, t0);
        mim(32'h4, 32'h0);
        repeat (6) @(posedge aclk);
        chk("irq raised", 32'h1, 32'(irq));
        rd(8'h34, got);
        rd(8'h38, t1);
        chk("stamp", 32'h1, 32'(got > t0 && got < t1));
        wr(8'h1c, 32'h0);
        repeat (3) @(posedge aclk);
        chk("irq masked", 32'h0, 32'(irq));
        rd(8'h20, got);
        chk("on flags", 32'h4, got);
        wr(8'h04, 32'h4);
        repeat (6) @(posedge aclk);
        rd(8'h24, got);
        chk("off dropped", 32'h0, got);
        ulo <= 32'ha5a5_0f0f;
        repeat (4) @(posedge aclk);
        chk("block", 32'ha5a5_0f0f, bk);
        chk("led", 32'h0000_0f0f, ld);
        chk("group relay", 32'h0, gp | ry);
        rd(8'h10, got);
        chk("out status", 32'ha5a5_0f0f, got);
        $display("events and outputs done");
        mim(32'h8, 32'h0);
        repeat (4) @(posedge aclk);
        aresetn <= 1'h0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        chk("restart clear", 32'h0, ci);
        summarize();
    end
endmodule
`default_nettype wire
